// file: design/uec_pkg.sv
// constants and types shared by the up/down event counter
package uec_pkg;
  localparam longint CLK_HZ = 200_000_000;
  localparam longint MIN_SHORT_MS = 100;
  localparam longint MIN_LONG_MS = 350;
  localparam longint MAX_PULSE_S = 30;
  // least times round up, the longest time is already whole cycles
  localparam longint MIN_SHORT_CYC = (MIN_SHORT_MS * CLK_HZ + 999) / 1000;
  localparam longint MIN_LONG_CYC = (MIN_LONG_MS * CLK_HZ + 999) / 1000;
  localparam longint MAX_PULSE_CYC = MAX_PULSE_S * CLK_HZ;
  localparam int PULSE_CNT_W = 34;
  localparam int CNT_W = 16;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [15:0] VALUE_MIN = 16'h0001;
  localparam logic [15:0] VALUE_MAX = 16'hFFFF;
  typedef enum logic [2:0] {
    UEC_UP_ONLY = 3'b001,
    UEC_DOWN_ONLY = 3'b010,
    UEC_UP_DOWN = 3'b100
  } uec_variant_t;
endpackage

// file: design/uec_pulse_qual.sv
// qualifies a low-high-low pulse by its high time
module uec_pulse_qual #(
  parameter longint MIN_SHORT = uec_pkg::MIN_SHORT_CYC,
  parameter longint MIN_LONG = uec_pkg::MIN_LONG_CYC,
  parameter longint MAX_LEN = uec_pkg::MAX_PULSE_CYC,
  parameter int CW = uec_pkg::PULSE_CNT_W
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // synchronised level and minimum select
  input wire logic level_i,
  input wire logic min_long_i,
  // one-cycle pulse after an accepted falling edge
  output logic valid_o
);
  localparam logic [CW-1:0] MIN_S = CW'(MIN_SHORT);
  localparam logic [CW-1:0] MIN_L = CW'(MIN_LONG);
  localparam logic [CW-1:0] MAX_C = CW'(MAX_LEN);
  localparam logic [CW-1:0] SAT_C = CW'(MAX_LEN + 1);

  logic [CW-1:0] high_len_reg;
  logic [CW-1:0] min_len;
  logic falling;

  assign min_len = min_long_i ? MIN_L : MIN_S;
  assign falling = !level_i && (high_len_reg != '0);

  // saturating count of high cycles; an overlong pulse stays above the limit
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      high_len_reg <= '0;
    end else if (level_i) begin
      if (high_len_reg != SAT_C) begin
        high_len_reg <= high_len_reg + 1'b1;
      end
    end else begin
      high_len_reg <= '0;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      valid_o <= 1'b0;
    end else begin
      valid_o <= falling && (high_len_reg >= min_len) && (high_len_reg <= MAX_C);
    end
  end

  a_pulse_window: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    valid_o |-> $past(high_len_reg) >= $past(min_len) && $past(high_len_reg) <= MAX_C
      && $past(level_i) == 1'b0)
    else $error("pulse accepted outside its length window");
endmodule

// file: design/uec_counter.sv
// up/down event counter with thresholds, clear and preload
module uec_counter #(
  parameter uec_pkg::uec_variant_t VARIANT = uec_pkg::UEC_UP_DOWN,
  parameter longint MIN_SHORT = uec_pkg::MIN_SHORT_CYC,
  parameter longint MIN_LONG = uec_pkg::MIN_LONG_CYC,
  parameter longint MAX_LEN = uec_pkg::MAX_PULSE_CYC
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic reset_n_i,
  // event and control pins
  input wire logic count_up_i,
  input wire logic count_down_i,
  input wire logic clear_in_i,
  input wire logic preload_in_i,
  // configuration, steady while running
  input wire logic [15:0] upper_thr_i,
  input wire logic [15:0] start_val_i,
  input wire logic wrap_auto_i,
  input wire logic reload_auto_i,
  input wire logic clear_min_long_i,
  input wire logic preload_min_long_i,
  // state
  output logic [15:0] count_o,
  output logic high_limit_o,
  output logic empty_o
);
  localparam bit HAS_UP = (VARIANT != uec_pkg::UEC_DOWN_ONLY);
  localparam bit HAS_DOWN = (VARIANT != uec_pkg::UEC_UP_ONLY);

  logic [3:0] sync1_reg;
  logic [3:0] sync2_reg;
  logic [1:0] prev_reg;
  logic up_edge;
  logic down_edge;
  logic clear_v;
  logic preload_v;
  logic [15:0] upper_eff;
  logic [15:0] start_eff;
  logic [15:0] count_next;
  logic high_next;
  logic empty_next;

  // every event and control pin passes two flops before anything reads it
  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      sync1_reg <= 4'h0;
      sync2_reg <= 4'h0;
    end else begin
      sync1_reg <= {preload_in_i, clear_in_i, count_down_i, count_up_i};
      sync2_reg <= sync1_reg;
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      prev_reg <= 2'h0;
    end else begin
      prev_reg <= sync2_reg[1:0];
    end
  end

  assign up_edge = HAS_UP && sync2_reg[0] && !prev_reg[0];
  assign down_edge = HAS_DOWN && sync2_reg[1] && !prev_reg[1];

  // zero settings are outside the legal range and read as the least value
  assign upper_eff = (upper_thr_i < uec_pkg::VALUE_MIN) ? uec_pkg::VALUE_MIN : upper_thr_i;
  assign start_eff = (start_val_i < uec_pkg::VALUE_MIN) ? uec_pkg::VALUE_MIN : start_val_i;

  uec_pulse_qual #(
    .MIN_SHORT(MIN_SHORT),
    .MIN_LONG(MIN_LONG),
    .MAX_LEN(MAX_LEN),
    .CW(uec_pkg::PULSE_CNT_W)
  ) u_clear_qual (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .level_i(sync2_reg[2]),
    .min_long_i(clear_min_long_i),
    .valid_o(clear_v)
  );

  uec_pulse_qual #(
    .MIN_SHORT(MIN_SHORT),
    .MIN_LONG(MIN_LONG),
    .MAX_LEN(MAX_LEN),
    .CW(uec_pkg::PULSE_CNT_W)
  ) u_preload_qual (
    .sys_clk_i(sys_clk_i),
    .reset_n_i(reset_n_i),
    .level_i(sync2_reg[3]),
    .min_long_i(preload_min_long_i),
    .valid_o(preload_v)
  );

  always_comb begin
    count_next = count_o;
    high_next = high_limit_o;
    empty_next = empty_o;
    if (clear_v) begin
      count_next = uec_pkg::COUNT_RST;
      high_next = 1'b0;
      empty_next = 1'b0;
    end else if (preload_v) begin
      count_next = start_eff;
      high_next = 1'b0;
      empty_next = 1'b0;
    end else if (high_limit_o && wrap_auto_i) begin
      // the flag stood for exactly one cycle; edges in this cycle are dropped
      count_next = uec_pkg::COUNT_RST;
      high_next = 1'b0;
    end else if (empty_o && reload_auto_i) begin
      count_next = start_eff;
      empty_next = 1'b0;
    end else if (up_edge && down_edge) begin
      count_next = count_o;
    end else if (up_edge) begin
      // at the threshold further increments are ignored (manual wrap)
      if (count_o < upper_eff && count_o != uec_pkg::VALUE_MAX) begin
        count_next = count_o + 16'h0001;
        high_next = (count_o + 16'h0001) == upper_eff;
        empty_next = 1'b0;
      end
    end else if (down_edge) begin
      // at zero further decrements are ignored (manual reload)
      if (count_o != uec_pkg::COUNT_RST) begin
        count_next = count_o - 16'h0001;
        empty_next = (count_o == 16'h0001);
        high_next = 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      count_o <= uec_pkg::COUNT_RST;
      high_limit_o <= 1'b0;
      empty_o <= 1'b0;
    end else begin
      count_o <= count_next;
      high_limit_o <= high_next;
      empty_o <= empty_next;
    end
  end

  a_clear_wins: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clear_v |=> count_o == 16'h0000 && !high_limit_o && !empty_o)
    else $error("clear did not zero count and flags");

  a_preload_loads: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    preload_v && !clear_v |=> count_o == $past(start_eff) && !high_limit_o && !empty_o)
    else $error("preload did not load start value");

  a_up_step: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !clear_v && !preload_v && !high_limit_o && !empty_o && up_edge && !down_edge
      && count_o < upper_eff |=> count_o == $past(count_o) + 16'h0001)
    else $error("increment missed");

  a_down_step: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !clear_v && !preload_v && !high_limit_o && !empty_o && down_edge && !up_edge
      && count_o != 16'h0000 |=> count_o == $past(count_o) - 16'h0001)
    else $error("decrement missed");

  a_both_edges: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    !clear_v && !preload_v && !high_limit_o && !empty_o && up_edge && down_edge
      |=> $stable(count_o))
    else $error("simultaneous edges changed the count");

  a_auto_wrap: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(high_limit_o) && wrap_auto_i && !clear_v && !preload_v
      |=> !high_limit_o && count_o == 16'h0000)
    else $error("automatic wrap did not clear after one cycle");

  a_auto_reload: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    empty_o && reload_auto_i && !high_limit_o && !clear_v && !preload_v
      |=> !empty_o && count_o == $past(start_eff))
    else $error("automatic reload did not load start value");

  a_manual_hold: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    high_limit_o && !wrap_auto_i && !clear_v && !preload_v && !down_edge
      |=> high_limit_o && $stable(count_o))
    else $error("manual high limit not held");

  a_flag_causes: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(empty_o) |-> count_o == 16'h0000 && $past(count_o) == 16'h0001)
    else $error("empty flag without reaching zero");

  a_limit_cause: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(high_limit_o) |-> count_o == upper_eff)
    else $error("high limit flag away from the threshold");

  a_manual_floor: assert property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    empty_o && !reload_auto_i && !clear_v && !preload_v && !up_edge
      |=> empty_o && $stable(count_o))
    else $error("manual empty flag not held");

  c_wrap: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(high_limit_o) ##1 count_o == 16'h0000);
  c_reload: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    $rose(empty_o) ##1 !empty_o);
  c_clear: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    clear_v && preload_v);
  c_hold_full: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    high_limit_o && !wrap_auto_i && up_edge);
  c_both_edges: cover property (@(posedge sys_clk_i) disable iff (!reset_n_i)
    up_edge && down_edge);
endmodule

// file: tb/uec_event_src.sv
// surrounding logic that drives the counter's event and control pins
module uec_event_src (
  // clock
  input wire logic sys_clk_i,
  // pins towards the counter
  output logic count_up_o,
  output logic count_down_o,
  output logic clear_in_o,
  output logic preload_in_o
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {count_up_o, count_down_o, clear_in_o, preload_in_o} = 4'h0;
  end
  // sel is {up, down, clear, preload}; pins move at the falling edge only
  task automatic pulse(input logic [3:0] sel, input int len);
    @(negedge sys_clk_i);
    {count_up_o, count_down_o, clear_in_o, preload_in_o} = sel;
    repeat (len) @(negedge sys_clk_i);
    {count_up_o, count_down_o, clear_in_o, preload_in_o} = 4'h0;
    // low long enough for the sync, edge and update stages to settle
    repeat (7) @(negedge sys_clk_i);
  endtask
endmodule

// file: tb/uec_counter_tb_top.sv
// self-checking bench for the up/down event counter
module uec_counter_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  logic sys_clk = 1'b0;
  logic reset_n = 1'b0;
  logic wrap_auto = 1'b0;
  logic reload_auto = 1'b0;
  logic clr_long = 1'b0;
  logic pre_long = 1'b1;
  logic [15:0] upper_thr = 16'h0005;
  logic [15:0] start_val = 16'h0003;
  localparam longint SIM_MIN_SHORT = 4;
  localparam longint SIM_MIN_LONG = 10;
  localparam longint SIM_MAX_LEN = 40;
  logic up, down, clr, pre, hl, em, hl_up;
  logic [15:0] cnt, cnt_up, cnt_dn;
  int n_errors = 0;
  int num_checks = 0;
  int hl_n = 0;
  int em_n = 0;
  always #2.5 sys_clk = ~sys_clk;
  // flag high-time counters show one-cycle pulses that happen inside a task
  always @(posedge sys_clk) begin
    if (hl === 1'b1) hl_n++;
    if (em === 1'b1) em_n++;
  end
  uec_event_src uec_event_src_i (.sys_clk_i(sys_clk), .count_up_o(up), .count_down_o(down),
    .clear_in_o(clr), .preload_in_o(pre));
  uec_counter #(.MIN_SHORT(SIM_MIN_SHORT), .MIN_LONG(SIM_MIN_LONG), .MAX_LEN(SIM_MAX_LEN))
    uec_counter_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .count_up_i(up), .count_down_i(down),
    .clear_in_i(clr), .preload_in_i(pre), .upper_thr_i(upper_thr), .start_val_i(start_val),
    .wrap_auto_i(wrap_auto), .reload_auto_i(reload_auto), .clear_min_long_i(clr_long),
    .preload_min_long_i(pre_long), .count_o(cnt), .high_limit_o(hl), .empty_o(em));
  // second variant shares the pins to show that down edges do nothing there;
  // its wrap stays manual, since flipping it while its limit flag stands breaks the hold
  uec_counter #(.VARIANT(uec_pkg::UEC_UP_ONLY), .MIN_SHORT(SIM_MIN_SHORT),
    .MIN_LONG(SIM_MIN_LONG), .MAX_LEN(SIM_MAX_LEN)) uec_counter_up_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .count_up_i(up), .count_down_i(down),
    .clear_in_i(clr), .preload_in_i(pre), .upper_thr_i(upper_thr), .start_val_i(start_val),
    .wrap_auto_i(1'b0), .reload_auto_i(1'b0), .clear_min_long_i(clr_long),
    .preload_min_long_i(pre_long), .count_o(cnt_up), .high_limit_o(hl_up), .empty_o());
  // third variant ignores up edges and sits at zero until the first preload
  uec_counter #(.VARIANT(uec_pkg::UEC_DOWN_ONLY), .MIN_SHORT(SIM_MIN_SHORT),
    .MIN_LONG(SIM_MIN_LONG), .MAX_LEN(SIM_MAX_LEN)) uec_counter_dn_i (
    .sys_clk_i(sys_clk), .reset_n_i(reset_n), .count_up_i(up), .count_down_i(down),
    .clear_in_i(clr), .preload_in_i(pre), .upper_thr_i(upper_thr), .start_val_i(start_val),
    .wrap_auto_i(wrap_auto), .reload_auto_i(reload_auto), .clear_min_long_i(clr_long),
    .preload_min_long_i(pre_long), .count_o(cnt_dn), .high_limit_o(), .empty_o());
  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("ERROR t=%0t seen=%0h exp=%0h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    if (n_errors == 0 && num_checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic s_manual_up();
    repeat (5) uec_event_src_i.pulse(4'h8, 1);
    chk(cnt, 16'h0005);
    chk({15'h0000, hl}, 16'h0001);
    uec_event_src_i.pulse(4'h8, 1);
    chk(cnt, 16'h0005);
    chk({15'h0000, hl}, 16'h0001);
    uec_event_src_i.pulse(4'h4, 1);
    chk(cnt, 16'h0004);
    chk({15'h0000, hl}, 16'h0000);
    uec_event_src_i.pulse(4'hC, 1);
    chk(cnt, 16'h0004);
    chk(cnt_up, 16'h0005);
    chk({15'h0000, hl_up}, 16'h0001);
    chk(cnt_dn, 16'h0000);
  endtask
  task automatic s_manual_down();
    repeat (4) uec_event_src_i.pulse(4'h4, 1);
    chk(cnt, 16'h0000);
    chk({15'h0000, em}, 16'h0001);
    uec_event_src_i.pulse(4'h4, 1);
    chk(cnt, 16'h0000);
    chk({15'h0000, em}, 16'h0001);
    uec_event_src_i.pulse(4'h8, 1);
    chk({15'h0000, em}, 16'h0000);
  endtask
  task automatic s_auto();
    wrap_auto = 1'b1;
    reload_auto = 1'b1;
    hl_n = 0;
    repeat (4) uec_event_src_i.pulse(4'h8, 1);
    chk(hl_n[15:0], 16'h0001);
    chk(cnt, 16'h0000);
    uec_event_src_i.pulse(4'h8, 1);
    em_n = 0;
    uec_event_src_i.pulse(4'h4, 1);
    chk(em_n[15:0], 16'h0001);
    chk(cnt, 16'h0003);
    wrap_auto = 1'b0;
    reload_auto = 1'b0;
  endtask
  task automatic s_control();
    repeat (2) uec_event_src_i.pulse(4'h8, 1);
    uec_event_src_i.pulse(4'h2, 3);
    chk(cnt, 16'h0005);
    uec_event_src_i.pulse(4'h2, 4);
    chk(cnt, 16'h0000);
    chk({15'h0000, hl}, 16'h0000);
    uec_event_src_i.pulse(4'h1, 9);
    chk(cnt, 16'h0000);
    uec_event_src_i.pulse(4'h1, 10);
    chk(cnt, 16'h0003);
    chk(cnt_dn, 16'h0003);
    uec_event_src_i.pulse(4'h4, 1);
    chk(cnt, 16'h0002);
    chk(cnt_dn, 16'h0002);
    uec_event_src_i.pulse(4'h2, 41);
    chk(cnt, 16'h0002);
    uec_event_src_i.pulse(4'h2, 40);
    chk(cnt, 16'h0000);
    uec_event_src_i.pulse(4'h1, 10);
    uec_event_src_i.pulse(4'h3, 10);
    chk(cnt, 16'h0000);
    chk({15'h0000, em}, 16'h0000);
  endtask
  initial begin
    #50us;
    n_errors++;
    report_and_stop();
  end
  initial begin
    repeat (10) @(posedge sys_clk);
    @(negedge sys_clk);
    reset_n = 1'b1;
    chk(cnt, 16'h0000);
    s_manual_up();
    s_manual_down();
    s_auto();
    s_control();
    report_and_stop();
  end
endmodule
